// ---- design/dpw_cmd_decoder.sv ----
// Dual pot wiper command decoder, serial bus slave with wiper and stored registers
//
// Function
// - Upper address nibble must equal the device-type code to proceed.
// - Lower address nibble must equal the pin address inputs, else ignore.
// - Instruction byte: opcode, setting select, pot select fields.
// - One 8-bit wiper position register per pot, two in all.
// - After reset each wiper loads from its first stored setting.
// - Four 8-bit stored settings per pot, readable, writable, exchangeable.
// - Every stored-setting change is a programming cycle of at most 10 ms.
// - Opcode 1001 returns the selected wiper position.
// - Opcode 1010 loads the data byte into the selected wiper.
// - Opcode 1011 returns the chosen stored setting.
// - Opcode 1100 writes the data byte into the chosen stored setting.
// - Opcode 1101 copies chosen stored setting into the pot's wiper.
// - Opcode 1110 copies the pot's wiper into the chosen stored setting.
// - Opcode 0001 copies chosen stored setting to wiper for both pots.
// - Opcode 1000 copies both wipers into their chosen stored settings.
// - Opcode 0010 enables stepping of the selected wiper.
// - Reads and writes are address, instruction and one data byte.
// - Transfers are address and instruction only, no data byte.
// - Wiper-to-stored copies take the write cycle; transfers lag by it too.
// - Stepping adds one per pulse with data high, subtracts with low.
// - Write-guard low: no acknowledge after stored-setting data, no programming of it; wiper-to-stored copies still program.
// - During a programming cycle the slave address is not acknowledged.
`timescale 1ns/10ps
module dpw_cmd_decoder #(
  parameter int NV_WRITE_CYCLES = dpw_pkg::NV_WRITE_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        wpN,
  input  wire logic [3:0]  pinAddr,
  output logic [7:0]       wiper0Pos,
  output logic [7:0]       wiper1Pos,
  output logic             nvBusy
);
  dpw_pkg::dpw_evt_s   evt;
  dpw_pkg::dpw_state_e state_r;
  dpw_pkg::dpw_state_e state_nxt;
  dpw_pkg::dpw_pend_s  pend_r;
  logic                wpNS;
  logic [3:0]          pinAddrS;
  logic [3:0]          bitCnt_r;
  logic                ackSlot_r;
  logic [7:0]          shift_r;
  logic [7:0]          txByte_r;
  logic [3:0]          op_r;
  logic                pot_r;
  logic [1:0]          sel_r;
  logic                sdaOe_r;
  logic                busy_r;
  logic [31:0]         nvCnt_r;
  logic [7:0]          wiper_r [dpw_pkg::NUM_POTS];
  logic [7:0]          stored_r [dpw_pkg::NUM_POTS][dpw_pkg::NUM_SETTINGS];
  logic                byteDone;
  logic                ackNow;
  logic                nvDone;
  logic                addrHit;

  ////////////////////////////////////////////////////////////////////////////
  // Accepts only the nine defined codes; P1 set names a pot that is absent
  function automatic logic instrOk(input logic [7:0] b);
    logic [3:0] op;
    logic [1:0] sel;
    logic [1:0] pot;
    op  = b[dpw_pkg::OPC_MSB:dpw_pkg::OPC_LSB];
    sel = b[dpw_pkg::SEL_MSB:dpw_pkg::SEL_LSB];
    pot = b[dpw_pkg::POT_MSB:dpw_pkg::POT_LSB];
    case (op)
      dpw_pkg::OP_READ_WIPER, dpw_pkg::OP_WRITE_WIPER, dpw_pkg::OP_STEP: instrOk = (sel == 2'h0) && !pot[1];
      dpw_pkg::OP_READ_STORED, dpw_pkg::OP_WRITE_STORED,
      dpw_pkg::OP_XFR_S2W, dpw_pkg::OP_XFR_W2S: instrOk = !pot[1];
      dpw_pkg::OP_GANG_S2W, dpw_pkg::OP_GANG_W2S: instrOk = (pot == 2'h0);
      default: instrOk = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] stepWiper(input logic [7:0] v, input logic up);
    if (up) begin
      stepWiper = (v == dpw_pkg::WIPER_MAX) ? v : v + 8'h01;
    end else begin
      stepWiper = (v == dpw_pkg::WIPER_MIN) ? v : v - 8'h01;
    end
  endfunction

  dpw_line_sync u_sync (
    .mclk     (mclk),
    .resetn   (resetn),
    .scl      (scl),
    .sdaIn    (sdaIn),
    .wpN      (wpN),
    .pinAddr  (pinAddr),
    .evt      (evt),
    .wpNS     (wpNS),
    .pinAddrS (pinAddrS)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bit framing: eight data clocks, then one acknowledge clock
  // Stepping pulses are not framed, so no pulse is swallowed by an acknowledge slot
  assign byteDone = evt.sclFall && (bitCnt_r == dpw_pkg::BYTE_LAST) && !ackSlot_r &&
                    (state_r != dpw_pkg::ST_STEP);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bitCnt_r  <= 4'h0;
      ackSlot_r <= 1'b0;
      shift_r   <= 8'h00;
    end else if (evt.start || evt.stop) begin
      bitCnt_r  <= 4'h0;
      ackSlot_r <= 1'b0;
    end else if (evt.sclRise) begin
      if (ackSlot_r) begin
        bitCnt_r <= 4'h0;
      end else if (bitCnt_r != dpw_pkg::BYTE_LAST) begin
        bitCnt_r <= bitCnt_r + 4'h1;
        shift_r  <= {shift_r[6:0], evt.sda};
      end
    end else if (evt.sclFall) begin
      if (byteDone) begin
        ackSlot_r <= 1'b1;
      end else if (ackSlot_r && bitCnt_r == 4'h0) begin
        ackSlot_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencing
  // address match
  assign addrHit = (shift_r[7:4] == dpw_pkg::DEV_TYPE) && (shift_r[3:0] == pinAddrS) && !busy_r;

  always_comb begin
    state_nxt = state_r;
    ackNow    = 1'b0;
    if (byteDone) begin
      unique case (state_r)
        dpw_pkg::ST_ADDR: begin
          ackNow    = addrHit;
          state_nxt = addrHit ? dpw_pkg::ST_INSTR : dpw_pkg::ST_IGNORE;
        end
        dpw_pkg::ST_INSTR: begin
          ackNow    = instrOk(shift_r);
          state_nxt = dpw_pkg::ST_IGNORE;
          if (ackNow) begin
            unique case (shift_r[dpw_pkg::OPC_MSB:dpw_pkg::OPC_LSB])
              dpw_pkg::OP_READ_WIPER, dpw_pkg::OP_READ_STORED: state_nxt = dpw_pkg::ST_RDATA;
              dpw_pkg::OP_WRITE_WIPER, dpw_pkg::OP_WRITE_STORED: state_nxt = dpw_pkg::ST_WDATA;
              dpw_pkg::OP_STEP: state_nxt = dpw_pkg::ST_STEP;
              default: state_nxt = dpw_pkg::ST_IGNORE;
            endcase
          end
        end
        dpw_pkg::ST_WDATA: begin
          ackNow    = (op_r == dpw_pkg::OP_WRITE_WIPER) || wpNS;
          state_nxt = dpw_pkg::ST_IGNORE;
        end
        dpw_pkg::ST_RECALL, dpw_pkg::ST_IDLE, dpw_pkg::ST_RDATA,
        dpw_pkg::ST_STEP, dpw_pkg::ST_IGNORE: state_nxt = state_r;
      endcase
    end else if (state_r == dpw_pkg::ST_RDATA && evt.sclRise && ackSlot_r && evt.sda) begin
      state_nxt = dpw_pkg::ST_IGNORE;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= dpw_pkg::ST_RECALL;
    end else if (state_r == dpw_pkg::ST_RECALL) begin
      state_r <= dpw_pkg::ST_IDLE;
    end else if (evt.start) begin
      state_r <= dpw_pkg::ST_ADDR;
    end else if (evt.stop) begin
      state_r <= dpw_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      op_r     <= 4'h0;
      pot_r    <= 1'b0;
      sel_r    <= 2'h0;
      txByte_r <= 8'h00;
    end else if (byteDone && state_r == dpw_pkg::ST_INSTR && ackNow) begin
      op_r  <= shift_r[dpw_pkg::OPC_MSB:dpw_pkg::OPC_LSB];
      pot_r <= shift_r[dpw_pkg::POT_LSB];
      sel_r <= shift_r[dpw_pkg::SEL_MSB:dpw_pkg::SEL_LSB];
      if (shift_r[dpw_pkg::OPC_MSB:dpw_pkg::OPC_LSB] == dpw_pkg::OP_READ_WIPER) begin
        txByte_r <= wiper_r[shift_r[dpw_pkg::POT_LSB]];
      end else begin
        txByte_r <= stored_r[shift_r[dpw_pkg::POT_LSB]][shift_r[dpw_pkg::SEL_MSB:dpw_pkg::SEL_LSB]];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain data pin: only ever pulls low
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sdaOe_r <= 1'b0;
    end else if (evt.start || evt.stop) begin
      sdaOe_r <= 1'b0;
    end else if (evt.sclFall) begin
      if (byteDone) begin
        sdaOe_r <= ackNow;
      end else if (state_r == dpw_pkg::ST_RDATA && bitCnt_r < dpw_pkg::BYTE_LAST) begin
        sdaOe_r <= ~txByte_r[3'(4'h7 - bitCnt_r)];
      end else begin
        sdaOe_r <= 1'b0;
      end
    end
  end

  assign sdaOe  = sdaOe_r;
  assign sdaOut = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Pending stored-setting work, executed when the programming cycle ends
  // pending command and data byte capture
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pend_r <= '0;
    end else if (nvDone) begin
      pend_r.valid <= 1'b0;
    end else if (evt.start && !busy_r) begin
      pend_r.valid <= 1'b0;
    end else if (byteDone && state_r == dpw_pkg::ST_INSTR && ackNow) begin
      pend_r.op    <= shift_r[dpw_pkg::OPC_MSB:dpw_pkg::OPC_LSB];
      pend_r.pot   <= shift_r[dpw_pkg::POT_LSB];
      pend_r.sel   <= shift_r[dpw_pkg::SEL_MSB:dpw_pkg::SEL_LSB];
      pend_r.valid <= shift_r[7:4] inside {dpw_pkg::OP_XFR_S2W, dpw_pkg::OP_XFR_W2S,
                                           dpw_pkg::OP_GANG_S2W, dpw_pkg::OP_GANG_W2S};
    end else if (byteDone && state_r == dpw_pkg::ST_WDATA && op_r == dpw_pkg::OP_WRITE_STORED && wpNS) begin
      pend_r.data  <= shift_r;
      pend_r.valid <= 1'b1;
    end
  end

  assign nvDone = busy_r && (nvCnt_r == 32'(NV_WRITE_CYCLES - 1));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busy_r  <= 1'b0;
      nvCnt_r <= 32'h0;
    end else if (busy_r) begin
      busy_r  <= !nvDone;
      nvCnt_r <= nvCnt_r + 32'h1;
    end else if (evt.stop && pend_r.valid) begin
      busy_r  <= 1'b1;
      nvCnt_r <= 32'h0;
    end
  end

  assign nvBusy = busy_r;

  ////////////////////////////////////////////////////////////////////////////
  // wiper updates
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < dpw_pkg::NUM_POTS; p++) begin
        wiper_r[p] <= dpw_pkg::WIPER_RESET;
      end
    end else if (state_r == dpw_pkg::ST_RECALL) begin
      for (int p = 0; p < dpw_pkg::NUM_POTS; p++) begin
        wiper_r[p] <= stored_r[p][0];
      end
    end else if (byteDone && state_r == dpw_pkg::ST_WDATA && op_r == dpw_pkg::OP_WRITE_WIPER) begin
      wiper_r[pot_r] <= shift_r;
    end else if (state_r == dpw_pkg::ST_STEP && evt.sclRise && !ackSlot_r && !evt.stop) begin
      wiper_r[pot_r] <= stepWiper(wiper_r[pot_r], evt.sda);
    end else if (nvDone && pend_r.op == dpw_pkg::OP_XFR_S2W) begin
      wiper_r[pend_r.pot] <= stored_r[pend_r.pot][pend_r.sel];
    end else if (nvDone && pend_r.op == dpw_pkg::OP_GANG_S2W) begin
      for (int p = 0; p < dpw_pkg::NUM_POTS; p++) begin
        wiper_r[p] <= stored_r[p][pend_r.sel];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < dpw_pkg::NUM_POTS; p++) begin
        for (int s = 0; s < dpw_pkg::NUM_SETTINGS; s++) begin
          stored_r[p][s] <= dpw_pkg::STORED_RESET;
        end
      end
    end else if (nvDone) begin
      if (pend_r.op == dpw_pkg::OP_WRITE_STORED) begin
        stored_r[pend_r.pot][pend_r.sel] <= pend_r.data;
      end else if (pend_r.op == dpw_pkg::OP_XFR_W2S) begin
        stored_r[pend_r.pot][pend_r.sel] <= wiper_r[pend_r.pot];
      end else if (pend_r.op == dpw_pkg::OP_GANG_W2S) begin
        for (int p = 0; p < dpw_pkg::NUM_POTS; p++) begin
          stored_r[p][pend_r.sel] <= wiper_r[p];
        end
      end
    end
  end

  assign wiper0Pos = wiper_r[0];
  assign wiper1Pos = wiper_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // address mismatch ignored
  addr_match_a: assert property (@(posedge mclk) disable iff (!resetn)
    byteDone && state_r == dpw_pkg::ST_ADDR && shift_r[3:0] != pinAddrS && !evt.start && !evt.stop
    |=> state_r == dpw_pkg::ST_IGNORE && !sdaOe) else $error("address mismatch was accepted");

  busy_nack_a: assert property (@(posedge mclk) disable iff (!resetn)
    byteDone && state_r == dpw_pkg::ST_ADDR && busy_r |=> !sdaOe) else $error("address acked while busy");

  bad_instr_a: assert property (@(posedge mclk) disable iff (!resetn)
    byteDone && state_r == dpw_pkg::ST_INSTR && !instrOk(shift_r) && !evt.start
    |=> state_r != dpw_pkg::ST_WDATA && state_r != dpw_pkg::ST_RDATA && !sdaOe && !pend_r.valid)
    else $error("undefined instruction acted on");

  read_wiper_a: assert property (@(posedge mclk) disable iff (!resetn)
    byteDone && state_r == dpw_pkg::ST_INSTR && ackNow && shift_r[7:4] == dpw_pkg::OP_READ_WIPER
    |=> txByte_r == $past(wiper_r[shift_r[0]])) else $error("read wiper returned wrong byte");

  step_up_a: assert property (@(posedge mclk) disable iff (!resetn)
    state_r == dpw_pkg::ST_STEP && evt.sclRise && !ackSlot_r && !evt.stop && evt.sda && wiper_r[pot_r] != 8'hFF
    |=> wiper_r[pot_r] == $past(wiper_r[pot_r]) + 8'h01) else $error("step up failed");

  step_floor_a: assert property (@(posedge mclk) disable iff (!resetn)
    state_r == dpw_pkg::ST_STEP && evt.sclRise && !evt.sda && wiper_r[pot_r] == 8'h00
    |=> wiper_r[pot_r] == 8'h00) else $error("wiper wrapped below zero");

  guard_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    byteDone && state_r == dpw_pkg::ST_WDATA && op_r == dpw_pkg::OP_WRITE_STORED && !wpNS && !evt.start
    |=> !sdaOe && !pend_r.valid) else $error("guarded stored write proceeded");

  nv_length_a: assert property (@(posedge mclk) disable iff (!resetn)
    busy_r |-> nvCnt_r < 32'(NV_WRITE_CYCLES)) else $error("programming cycle overran");

  wiper_recall_a: assert property (@(posedge mclk) disable iff (!resetn)
    state_r == dpw_pkg::ST_RECALL |=> wiper_r[0] == $past(stored_r[0][0]) && wiper_r[1] == $past(stored_r[1][0]))
    else $error("wiper not recalled from first stored setting");
endmodule

// ---- design/dpw_pkg.sv ----
// Shared constants, types and states of the dual pot wiper command decoder
package dpw_pkg;
  localparam int          CLK_HZ          = 50_000_000;
  localparam int          NV_WRITE_MS     = 10;
  localparam int          NV_WRITE_CYCLES = CLK_HZ / 1000 * NV_WRITE_MS;
  localparam int          NUM_POTS        = 2;
  localparam int          NUM_SETTINGS    = 4;
  // Device-type code: value is arbitrary
  localparam logic [3:0]  DEV_TYPE        = 4'hA;
  localparam logic [3:0]  BYTE_LAST       = 4'h8;
  localparam int          OPC_MSB         = 7;
  localparam int          OPC_LSB         = 4;
  localparam int          SEL_MSB         = 3;
  localparam int          SEL_LSB         = 2;
  localparam int          POT_MSB         = 1;
  localparam int          POT_LSB         = 0;
  localparam logic [7:0]  WIPER_RESET     = 8'h00;
  localparam logic [7:0]  STORED_RESET    = 8'h80;
  localparam logic [7:0]  WIPER_MAX       = 8'hFF;
  localparam logic [7:0]  WIPER_MIN       = 8'h00;
  localparam logic [3:0]  OP_GANG_S2W     = 4'h1;
  localparam logic [3:0]  OP_STEP         = 4'h2;
  localparam logic [3:0]  OP_GANG_W2S     = 4'h8;
  localparam logic [3:0]  OP_READ_WIPER   = 4'h9;
  localparam logic [3:0]  OP_WRITE_WIPER  = 4'hA;
  localparam logic [3:0]  OP_READ_STORED  = 4'hB;
  localparam logic [3:0]  OP_WRITE_STORED = 4'hC;
  localparam logic [3:0]  OP_XFR_S2W      = 4'hD;
  localparam logic [3:0]  OP_XFR_W2S      = 4'hE;

  typedef enum logic [2:0] {
    ST_RECALL, ST_IDLE, ST_ADDR, ST_INSTR, ST_WDATA, ST_RDATA, ST_STEP, ST_IGNORE
  } dpw_state_e;

  typedef struct packed {
    logic sclRise;
    logic sclFall;
    logic start;
    logic stop;
    logic sda;
  } dpw_evt_s;

  typedef struct packed {
    logic       valid;
    logic [3:0] op;
    logic       pot;
    logic [1:0] sel;
    logic [7:0] data;
  } dpw_pend_s;
endpackage

// ---- design/dpw_line_sync.sv ----
// Pin synchronisers and serial bus edge, START and STOP detection
`timescale 1ns/10ps
module dpw_line_sync (
  input  wire logic          mclk,
  input  wire logic          resetn,
  input  wire logic          scl,
  input  wire logic          sdaIn,
  input  wire logic          wpN,
  input  wire logic [3:0]    pinAddr,
  output dpw_pkg::dpw_evt_s  evt,
  output logic               wpNS,
  output logic [3:0]         pinAddrS
);
  logic [6:0] meta_r;
  logic [6:0] sync_r;
  logic       sclPrev_r;
  logic       sdaPrev_r;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 7'h7F;
      sync_r <= 7'h7F;
    end else begin
      meta_r <= {scl, sdaIn, wpN, pinAddr};
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= sync_r[6];
      sdaPrev_r <= sync_r[5];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data change while the clock stays high is framing, not data
  assign evt.sclRise = sync_r[6] & ~sclPrev_r;
  assign evt.sclFall = ~sync_r[6] & sclPrev_r;
  assign evt.start   = sync_r[6] & sclPrev_r & sdaPrev_r & ~sync_r[5];
  assign evt.stop    = sync_r[6] & sclPrev_r & ~sdaPrev_r & sync_r[5];
  assign evt.sda     = sync_r[5];
  assign wpNS        = sync_r[4];
  assign pinAddrS    = sync_r[3:0];
endmodule

// ---- test/dpw_bus_master.sv ----
// Behavioural serial bus master that frames commands for the pot decoder
`timescale 1ns/10ps
module dpw_bus_master (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sdaDrv
);
  // Low and high phase in mclk cycles; the bench stretches it to act as a slow master
  int halfCyc = 8;

  initial begin
    scl    = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic waitn(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Data moves one cycle after the clock falls, so it never reads as START or STOP
  task automatic clkBit(input logic b, output logic s);
    sdaDrv = b;
    waitn(halfCyc);
    scl = 1'b1;
    waitn(halfCyc / 2);
    s = sda;
    waitn(halfCyc / 2);
    scl = 1'b0;
    waitn(1);
  endtask

  task automatic busStart();
    sdaDrv = 1'b1;
    waitn(halfCyc);
    scl = 1'b1;
    waitn(halfCyc);
    sdaDrv = 1'b0;
    waitn(halfCyc);
    scl = 1'b0;
    waitn(1);
  endtask

  task automatic busStop();
    sdaDrv = 1'b0;
    waitn(halfCyc);
    scl = 1'b1;
    waitn(halfCyc);
    sdaDrv = 1'b1;
    waitn(halfCyc);
  endtask

  task automatic xfer(input logic [7:0] d, input logic mAck, output logic [7:0] q, output logic ackSeen);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clkBit(d[i], s);
      q[i] = s;
    end
    clkBit(~mAck, s);
    ackSeen = ~s;
  endtask

  task automatic stepPulse(input logic up);
    logic s;
    clkBit(up, s);
  endtask
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the dual pot wiper command decoder
`timescale 1ns/10ps
module testbench;
  localparam int NV = 400;
  logic       mclk     = 1'b0;
  logic       resetn   = 1'b0;
  logic       wpN      = 1'b1;
  logic [3:0] pinAddr  = 4'h0;
  logic       scl;
  logic       sdaDrv;
  logic       sdaW;
  logic       sdaOut;
  logic       sdaOe;
  logic       nvBusy;
  logic [7:0] wiper0Pos;
  logic [7:0] wiper1Pos;
  logic [7:0] me;
  logic [7:0] expW [2];
  logic [7:0] expS [2][4];
  int         busyLen  = 0;
  int         errCount = 0;
  int         cmpCount = 0;

  always #10 mclk = ~mclk;
  // Open-drain data wire with pull-up
  assign sdaW = sdaDrv & ~sdaOe;
  assign me   = {dpw_pkg::DEV_TYPE, pinAddr};

  dpw_bus_master dpw_bus_master_inst (.mclk(mclk), .sda(sdaW), .scl(scl), .sdaDrv(sdaDrv));
  dpw_cmd_decoder #(.NV_WRITE_CYCLES(NV)) dpw_cmd_decoder_inst (
    .mclk(mclk), .resetn(resetn), .scl(scl), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .wpN(wpN), .pinAddr(pinAddr), .wiper0Pos(wiper0Pos), .wiper1Pos(wiper1Pos), .nvBusy(nvBusy));

  task automatic endOfTest();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmpCount++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkW();
    chk("wiper0", expW[0], wiper0Pos);
    chk("wiper1", expW[1], wiper1Pos);
  endtask

  function automatic logic [7:0] ins(logic [3:0] op, int sel, int pot);
    return {op, 2'(sel), 2'(pot)};
  endfunction

  function automatic logic [7:0] stepV(logic [7:0] v, logic up);
    if (up) return (v == 8'hFF) ? v : v + 8'h01;
    return (v == 8'h00) ? v : v - 8'h01;
  endfunction

  // Programming span lasts exactly the write cycle; sampled away from the launching edge
  always @(negedge mclk) begin
    if (nvBusy === 1'b1) busyLen <= busyLen + 1;
    else if (busyLen != 0) begin
      chk("busy span ok", 8'h01, {7'h00, busyLen == NV});
      busyLen <= 0;
    end
  end

  task automatic run(input logic [7:0] a, i, d, input int nd, input logic [2:0] ea, input logic nv,
                     output logic [7:0] rd);
    logic [2:0] ack;
    logic [7:0] q;
    logic       pk;
    dpw_bus_master_inst.busStart();
    dpw_bus_master_inst.xfer(a, 1'b0, rd, ack[2]);
    dpw_bus_master_inst.xfer(i, 1'b0, rd, ack[1]);
    ack[0] = 1'b0;
    if (nd != 0) dpw_bus_master_inst.xfer(d, 1'b0, rd, ack[0]);
    dpw_bus_master_inst.busStop();
    chk("acks", {5'h00, ea}, {5'h00, ack});
    chkW();
    for (int n = 0; n < 8 && nvBusy !== nv; n++) @(negedge mclk);
    chk("busy", {7'h00, nv}, {7'h00, nvBusy});
    if (nv) begin
      dpw_bus_master_inst.busStart();
      dpw_bus_master_inst.xfer(a, 1'b0, q, pk);
      dpw_bus_master_inst.busStop();
      chk("poll ack", 8'h00, {7'h00, pk});
      for (int n = 0; n < NV && nvBusy === 1'b1; n++) @(negedge mclk);
      chk("busy end", 8'h00, {7'h00, nvBusy});
    end
  endtask

  task automatic rdS(input int p, s);
    logic [7:0] rd;
    run(me, ins(dpw_pkg::OP_READ_STORED, s, p), 8'hFF, 1, 3'b110, 1'b0, rd);
    chk("stored read", expS[p][s], rd);
  endtask

  task automatic wrW(input int p, input logic [7:0] v);
    logic [7:0] rd;
    expW[p] = v;
    run(me, ins(dpw_pkg::OP_WRITE_WIPER, 0, p), v, 1, 3'b111, 1'b0, rd);
    run(me, ins(dpw_pkg::OP_READ_WIPER, 0, p), 8'hFF, 1, 3'b110, 1'b0, rd);
    chk("wiper read", v, rd);
  endtask

  initial begin
    repeat (95000) @(posedge mclk);
    errCount++;
    $display("[FAIL] watchdog expected finish seen hang");
    endOfTest();
  end

  initial begin
    logic [7:0] rd;
    logic [7:0] v;
    logic       a1;
    logic       a2;
    logic       dir;
    int         p;
    int         s;
    logic [3:0] bad [7];
    bad = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF};
    void'($urandom(32'h9025268e));
    pinAddr = 4'($urandom);
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    repeat (8) @(negedge mclk);
    expW = '{8'h80, 8'h80};
    chkW();
    for (int pp = 0; pp < 2; pp++) begin
      for (int ss = 0; ss < 4; ss++) begin
        expS[pp][ss] = 8'h80;
        rdS(pp, ss);
      end
    end
    for (int k = 0; k < 4; k++) begin
      p = $urandom_range(1, 0);
      s = $urandom_range(3, 0);
      dpw_bus_master_inst.halfCyc = (k % 2 == 1) ? 12 : 8;
      wrW(p, 8'($urandom));
      v = 8'($urandom);
      expS[p][s] = v;
      run(me, ins(dpw_pkg::OP_WRITE_STORED, s, p), v, 1, 3'b111, 1'b1, rd);
      rdS(p, s);
      s = $urandom_range(3, 0);
      expS[p][s] = expW[p];
      run(me, ins(dpw_pkg::OP_XFR_W2S, s, p), 8'h00, 0, 3'b110, 1'b1, rd);
      rdS(p, s);
      s = $urandom_range(3, 0);
      run(me, ins(dpw_pkg::OP_XFR_S2W, s, p), 8'h00, 0, 3'b110, 1'b1, rd);
      expW[p] = expS[p][s];
      chkW();
      wrW(1 - p, 8'($urandom));
      run(me, ins(dpw_pkg::OP_GANG_W2S, s, 0), 8'h00, 0, 3'b110, 1'b1, rd);
      expS[0][s] = expW[0];
      expS[1][s] = expW[1];
      rdS(0, s);
      rdS(1, s);
      s = $urandom_range(3, 0);
      run(me, ins(dpw_pkg::OP_GANG_S2W, s, 0), 8'h00, 0, 3'b110, 1'b1, rd);
      expW = '{expS[0][s], expS[1][s]};
      chkW();
    end
    // Closing clock rise of the frame steps too, so each frame ends at a saturated code
    // Ten pulses run past one byte length: no pulse may be lost to byte framing
    for (int u = 0; u < 2; u++) begin
      wrW(p, (u == 0) ? 8'hFE : 8'h01);
      dpw_bus_master_inst.busStart();
      dpw_bus_master_inst.xfer(me, 1'b0, rd, a1);
      dpw_bus_master_inst.xfer(ins(dpw_pkg::OP_STEP, 0, p), 1'b0, rd, a2);
      chk("step acks", 8'h03, {6'h00, a1, a2});
      for (int n = 0; n < 10; n++) begin
        dir = (n == 2) == (u == 1);
        dpw_bus_master_inst.stepPulse(dir);
        expW[p] = stepV(expW[p], dir);
        chkW();
      end
      if (u == 0) dpw_bus_master_inst.busStart();
      dpw_bus_master_inst.busStop();
      chkW();
    end
    run({dpw_pkg::DEV_TYPE ^ 4'h8, pinAddr}, ins(dpw_pkg::OP_WRITE_WIPER, 0, 0), 8'h3C, 1, 3'b000, 1'b0, rd);
    run({dpw_pkg::DEV_TYPE, pinAddr ^ 4'h1}, ins(dpw_pkg::OP_WRITE_WIPER, 0, 1), 8'h3C, 1, 3'b000, 1'b0, rd);
    for (int n = 0; n < 7; n++) run(me, {bad[n], 4'h0}, 8'h00, 0, 3'b100, 1'b0, rd);
    run(me, ins(dpw_pkg::OP_WRITE_WIPER, 0, 2), 8'h00, 0, 3'b100, 1'b0, rd);
    wpN = 1'b0;
    run(me, ins(dpw_pkg::OP_WRITE_STORED, 1, 0), ~expS[0][1], 1, 3'b110, 1'b0, rd);
    wpN = 1'b1;
    rdS(0, 1);
    // Master acknowledge on read data asks for the same byte again
    dpw_bus_master_inst.busStart();
    dpw_bus_master_inst.xfer(me, 1'b0, rd, a1);
    dpw_bus_master_inst.xfer(ins(dpw_pkg::OP_READ_STORED, 1, 0), 1'b0, rd, a2);
    dpw_bus_master_inst.xfer(8'hFF, 1'b1, rd, a1);
    dpw_bus_master_inst.xfer(8'hFF, 1'b0, v, a2);
    dpw_bus_master_inst.busStop();
    chk("read first", expS[0][1], rd);
    chk("read repeat", expS[0][1], v);
    chk("sda out", 8'h00, {7'h00, sdaOut});
    endOfTest();
  end
endmodule
